// ===== rtl/sdpc_pkg.sv
// constants, command codes and types shared by the sdram pin control block
package sdpc_pkg;
  typedef enum logic [2:0] {PWR_RUN, PWR_PD_PRE, PWR_PD_ACT, PWR_SELF_REF, PWR_SUSPEND} sdpc_pwr_e;

  // {select, row strobe, column strobe, write enable}, all active low
  localparam logic [3:0] CMD_LMR = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_BST = 4'h6;
  localparam logic [3:0] CMD_NOP = 4'h7;

  // burst length select codes
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam int BEATS_1 = 1;
  localparam int BEATS_2 = 2;
  localparam int BEATS_4 = 4;
  localparam int BEATS_8 = 8;

  localparam int BANKS = 4;
  localparam int BA_W = 2;
  localparam int ADDR_W = 13;
  localparam int AP_BIT = 10;
  localparam int DQ_W = 16;
  localparam int LANES = 2;
  localparam int LANE_W = 8;
  localparam int FIFO_DEPTH = 8;
endpackage

// ===== rtl/sdpc_strm_if.sv
// valid/ready stream carrier between the core and its write fifo
`timescale 1ns/100ps
interface sdpc_strm_if #(
  parameter int WIDTH = 8
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ===== rtl/sdpc_fifo.sv
// write-beat fifo with parameterised width and depth
`timescale 1ns/100ps
module sdpc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  sdpc_strm_if.snk in_s,
  sdpc_strm_if.src out_s
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } sdpc_fifo_s;

  sdpc_fifo_s s_q;
  sdpc_fifo_s s_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_s.ready = (s_q.cnt != FULL_CNT);
  assign out_s.valid = (s_q.cnt != '0);
  assign out_s.data = mem[s_q.rp];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  always_comb
  begin
    s_d = s_q;
    if (push)
    begin
      s_d.wp = (s_q.wp == LAST_PTR) ? '0 : s_q.wp + 1'b1;
    end
    if (pop)
    begin
      s_d.rp = (s_q.rp == LAST_PTR) ? '0 : s_q.rp + 1'b1;
    end
    if (push && !pop)
    begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
    else if (pop && !push)
    begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (push)
    begin
      mem[s_q.wp] <= in_s.data;
    end
  end
endmodule

// ===== rtl/sdpc_core.sv
// sdram device-side pin control: clock gate, command decode, bursts, byte masks, array
`timescale 1ns/100ps
module sdpc_core #(
  parameter int COL_W = 9,
  parameter int MEM_ROW_W = 2
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [sdpc_pkg::BA_W-1:0] ba_i,
  input wire logic [sdpc_pkg::ADDR_W-1:0] addr_i,
  input wire logic [2:0] burst_len_sel_i,
  input wire logic lower_byte_mask_i,
  input wire logic upper_byte_mask_i,
  input wire logic [sdpc_pkg::DQ_W-1:0] dq_i,
  output logic [sdpc_pkg::DQ_W-1:0] dq_o,
  output logic [sdpc_pkg::LANES-1:0] dq_oe_o,
  output logic [sdpc_pkg::BANKS-1:0] bank_open_o,
  output logic [2:0] pwr_state_o
);
  localparam int MEM_AW = sdpc_pkg::BA_W + MEM_ROW_W + COL_W;
  localparam int FW = MEM_AW + sdpc_pkg::LANES + sdpc_pkg::DQ_W;
  localparam int MEM_DEPTH = 1 << MEM_AW;
  localparam logic [COL_W:0] LEN_1 = (COL_W+1)'(sdpc_pkg::BEATS_1);
  localparam logic [COL_W:0] LEN_2 = (COL_W+1)'(sdpc_pkg::BEATS_2);
  localparam logic [COL_W:0] LEN_4 = (COL_W+1)'(sdpc_pkg::BEATS_4);
  localparam logic [COL_W:0] LEN_8 = (COL_W+1)'(sdpc_pkg::BEATS_8);
  localparam logic [COL_W:0] LEN_PAGE = (COL_W+1)'(1) << COL_W;

  typedef struct packed {
    sdpc_pkg::sdpc_pwr_e pwr;
    logic [sdpc_pkg::BANKS-1:0] open;
    logic [sdpc_pkg::BANKS-1:0][sdpc_pkg::ADDR_W-1:0] row;
    logic burst;
    logic bwr;
    logic bap;
    logic [sdpc_pkg::BA_W-1:0] bbank;
    logic [COL_W-1:0] bstart;
    logic [COL_W:0] bidx;
    logic [COL_W:0] blen;
    logic rd1_v;
    logic [sdpc_pkg::DQ_W-1:0] rd1_d;
    logic [sdpc_pkg::LANES-1:0] m1;
    logic [sdpc_pkg::DQ_W-1:0] dq;
    logic [sdpc_pkg::LANES-1:0] oe;
  } sdpc_state_s;

  sdpc_state_s s_q;
  sdpc_state_s s_d;
  logic [sdpc_pkg::DQ_W-1:0] mem [MEM_DEPTH];
  logic [3:0] cmd;
  logic act;
  logic fetch;
  logic push_v;
  logic [FW-1:0] push_data;
  logic [sdpc_pkg::LANES-1:0] mask;
  logic [COL_W-1:0] cur_col;
  logic [MEM_AW-1:0] cur_idx;
  logic [MEM_AW-1:0] w_idx;
  logic [sdpc_pkg::LANES-1:0] w_mask;
  logic [sdpc_pkg::DQ_W-1:0] w_data;

  sdpc_strm_if #(.WIDTH(FW)) fill_s ();
  sdpc_strm_if #(.WIDTH(FW)) drain_s ();

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [COL_W:0] len_of(input logic [2:0] sel);
    logic [COL_W:0] l;
    case (sel)
      sdpc_pkg::BL_1: l = LEN_1;
      sdpc_pkg::BL_2: l = LEN_2;
      sdpc_pkg::BL_4: l = LEN_4;
      sdpc_pkg::BL_8: l = LEN_8;
      sdpc_pkg::BL_PAGE: l = LEN_PAGE;
      default: l = LEN_1;
    endcase
    return l;
  endfunction

  // sequential order, wrapping inside the burst-length block
  function automatic logic [COL_W-1:0] col_of(input logic [COL_W-1:0] start, input logic [COL_W:0] idx,
                                              input logic [COL_W:0] len);
    logic [COL_W:0] m;
    logic [COL_W-1:0] sum;
    m = len - 1'b1;
    sum = start + idx[COL_W-1:0];
    return (start & ~m[COL_W-1:0]) | (sum & m[COL_W-1:0]);
  endfunction

  // ----------------------------------------
  // pin decode and write fifo
  // ----------------------------------------
  assign cmd = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
  assign mask = {upper_byte_mask_i, lower_byte_mask_i};
  assign act = (s_q.pwr == sdpc_pkg::PWR_RUN) && cke_i;
  assign cur_col = col_of(s_q.bstart, s_q.bidx, s_q.blen);
  assign cur_idx = {s_q.bbank, s_q.row[s_q.bbank][MEM_ROW_W-1:0], cur_col};
  assign fill_s.valid = push_v;
  assign fill_s.data = push_data;
  assign drain_s.ready = !fetch;
  assign {w_idx, w_mask, w_data} = drain_s.data;

  sdpc_fifo #(.WIDTH(FW), .DEPTH(sdpc_pkg::FIFO_DEPTH)) u_wfifo (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .in_s(fill_s),
    .out_s(drain_s)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    s_d = s_q;
    fetch = 1'b0;
    push_v = 1'b0;
    push_data = '0;
    if (s_q.pwr != sdpc_pkg::PWR_RUN)
    begin
      if (cke_i)
      begin
        s_d.pwr = sdpc_pkg::PWR_RUN;
      end
    end
    else if (!cke_i)
    begin
      if (s_q.burst)
      begin
        s_d.pwr = sdpc_pkg::PWR_SUSPEND;
      end
      else if (|s_q.open)
      begin
        s_d.pwr = sdpc_pkg::PWR_PD_ACT;
      end
      else if (cmd == sdpc_pkg::CMD_REF)
      begin
        s_d.pwr = sdpc_pkg::PWR_SELF_REF;
      end
      else
      begin
        s_d.pwr = sdpc_pkg::PWR_PD_PRE;
      end
    end
    else
    begin
      s_d.m1 = mask;
      s_d.oe = {sdpc_pkg::LANES{s_q.rd1_v}} & ~s_q.m1;
      s_d.dq = s_q.rd1_d;
      s_d.rd1_v = 1'b0;
      if (s_q.burst)
      begin
        if (!s_q.bwr)
        begin
          fetch = 1'b1;
          s_d.rd1_v = 1'b1;
          s_d.rd1_d = mem[cur_idx];
        end
        else if (fill_s.ready)
        begin
          push_v = 1'b1;
          push_data = {cur_idx, mask, dq_i};
        end
        if (!s_q.bwr || fill_s.ready)
        begin
          s_d.bidx = s_q.bidx + 1'b1;
          if (s_d.bidx == s_q.blen)
          begin
            s_d.burst = 1'b0;
            if (s_q.bap)
            begin
              s_d.open[s_q.bbank] = 1'b0;
            end
          end
        end
      end
      case (cmd)
        sdpc_pkg::CMD_ACT:
        begin
          s_d.open[ba_i] = 1'b1;
          s_d.row[ba_i] = addr_i;
        end
        sdpc_pkg::CMD_READ, sdpc_pkg::CMD_WRITE:
        begin
          s_d.burst = 1'b1;
          s_d.bwr = (cmd == sdpc_pkg::CMD_WRITE);
          s_d.bbank = ba_i;
          s_d.bstart = addr_i[COL_W-1:0];
          s_d.bap = addr_i[sdpc_pkg::AP_BIT];
          s_d.blen = len_of(burst_len_sel_i);
          s_d.bidx = '0;
          if (cmd == sdpc_pkg::CMD_WRITE && fill_s.ready)
          begin
            push_v = 1'b1;
            push_data = {ba_i, s_q.row[ba_i][MEM_ROW_W-1:0], addr_i[COL_W-1:0], mask, dq_i};
            s_d.bidx = LEN_1;
            if (s_d.blen == LEN_1)
            begin
              s_d.burst = 1'b0;
              if (addr_i[sdpc_pkg::AP_BIT])
              begin
                s_d.open[ba_i] = 1'b0;
              end
            end
          end
        end
        sdpc_pkg::CMD_BST:
        begin
          s_d.burst = 1'b0;
        end
        sdpc_pkg::CMD_PRE:
        begin
          if (addr_i[sdpc_pkg::AP_BIT])
          begin
            s_d.open = '0;
          end
          else
          begin
            s_d.open[ba_i] = 1'b0;
          end
        end
        default:
        begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // registers and array
  // ----------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (drain_s.valid && drain_s.ready)
    begin
      for (int l = 0; l < sdpc_pkg::LANES; l++)
      begin
        if (!w_mask[l])
        begin
          mem[w_idx][l*sdpc_pkg::LANE_W +: sdpc_pkg::LANE_W] <= w_data[l*sdpc_pkg::LANE_W +: sdpc_pkg::LANE_W];
        end
      end
    end
  end

  assign dq_o = s_q.dq;
  assign dq_oe_o = s_q.oe;
  assign bank_open_o = s_q.open;
  assign pwr_state_o = s_q.pwr;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  cs_high_masks_a: assert property (act && cs_n_i && !s_q.burst |=> $stable(s_q.open))
    else $error("command taken while deselected");
  gate_low_hold_a: assert property ((s_q.pwr != sdpc_pkg::PWR_RUN) && !cke_i |=>
    $stable(s_q.open) && $stable(s_q.bidx) && $stable(dq_o) && $stable(dq_oe_o))
    else $error("state moved while clock gated");
  suspend_entry_a: assert property (s_q.pwr == sdpc_pkg::PWR_RUN && !cke_i && s_q.burst |=>
    s_q.pwr == sdpc_pkg::PWR_SUSPEND)
    else $error("no clock suspend during burst");
  active_pd_a: assert property (s_q.pwr == sdpc_pkg::PWR_RUN && !cke_i && !s_q.burst && (|s_q.open) |=>
    s_q.pwr == sdpc_pkg::PWR_PD_ACT)
    else $error("no active power-down with open row");
  gate_wake_a: assert property (s_q.pwr != sdpc_pkg::PWR_RUN && cke_i |=> s_q.pwr == sdpc_pkg::PWR_RUN)
    else $error("no exit on clock gate high");
  read_mask_hiz_a: assert property (act && lower_byte_mask_i ##1 act |=> !dq_oe_o[0])
    else $error("low lane driven two cycles after mask");
  read_beat_a: assert property (act && s_q.burst && !s_q.bwr |=> s_q.rd1_v)
    else $error("read burst did not advance");
  precharge_all_a: assert property (act && cmd == sdpc_pkg::CMD_PRE && addr_i[sdpc_pkg::AP_BIT] |=>
    s_q.open == '0)
    else $error("precharge all left a bank open");
  activate_bank_a: assert property (act && cmd == sdpc_pkg::CMD_ACT |=> s_q.open[$past(ba_i)])
    else $error("activate did not open chosen bank");
  write_mask_push_a: assert property (act && cmd == sdpc_pkg::CMD_WRITE && fill_s.ready |->
    push_v && push_data[sdpc_pkg::DQ_W +: sdpc_pkg::LANES] == mask)
    else $error("write beat queued without its mask");
  single_beat_a: assert property (act && cmd == sdpc_pkg::CMD_READ && burst_len_sel_i == sdpc_pkg::BL_1
    ##1 (act && cs_n_i) |=> !s_q.burst)
    else $error("one-beat read ran on");

  read_burst_c: cover property (act && cmd == sdpc_pkg::CMD_READ ##3 dq_oe_o == 2'h3);
  self_ref_c: cover property (s_q.pwr == sdpc_pkg::PWR_SELF_REF ##1 s_q.pwr == sdpc_pkg::PWR_RUN);
  suspend_c: cover property (s_q.pwr == sdpc_pkg::PWR_SUSPEND);
  fifo_full_c: cover property (!fill_s.ready);
endmodule

// ===== tb/sdpc_ctrl_model.sv
// controller-side pin model that drives the sdram pin control core
`timescale 1ns/100ps
module sdpc_ctrl_model (
  input wire logic clock_i,
  output logic cke_o,
  output logic cs_n_o,
  output logic ras_n_o,
  output logic cas_n_o,
  output logic we_n_o,
  output logic [1:0] ba_o,
  output logic [12:0] addr_o,
  output logic [2:0] burst_len_sel_o,
  output logic lower_byte_mask_o,
  output logic upper_byte_mask_o,
  output logic [15:0] dq_o
);
  // ----------------------------------------
  // idle pin levels
  // ----------------------------------------
  initial
  begin
    cke_o = 1'b1;
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hF;
    ba_o = 2'h0;
    addr_o = 13'h0000;
    burst_len_sel_o = 3'h0;
    {upper_byte_mask_o, lower_byte_mask_o} = 2'h0;
    dq_o = 16'h0000;
  end

  // ----------------------------------------
  // one command cycle, launched after a falling edge
  // ----------------------------------------
  task automatic drive(
    input logic [3:0] code,
    input logic [1:0] ba,
    input logic [12:0] addr,
    input logic [15:0] data = 16'h0000,
    input logic [1:0] mask = 2'h0
  );
    @(negedge clock_i);
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = code;
    ba_o = ba;
    addr_o = addr;
    dq_o = data;
    {upper_byte_mask_o, lower_byte_mask_o} = mask;
  endtask

  // deselected cycles; data bus is not held, so it toggles
  task automatic idle(input int n);
    repeat (n)
    begin
      @(negedge clock_i);
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hF;
      {upper_byte_mask_o, lower_byte_mask_o} = 2'h0;
      dq_o = ~dq_o;
    end
  endtask

  task automatic set_pins(input logic cke, input logic [2:0] len);
    cke_o = cke;
    burst_len_sel_o = len;
  endtask
endmodule

// ===== tb/tb.sv
// self-checking testbench for the sdram pin control core
`timescale 1ns/100ps
module tb;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic cke, cs_n, ras_n, cas_n, we_n, lmask, umask;
  logic [1:0] ba;
  logic [12:0] addr;
  logic [2:0] bl;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [1:0] oe;
  logic [3:0] bank_open;
  logic [2:0] pwr;
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;

  always #4 clock_i = ~clock_i;

  sdpc_ctrl_model i_sdpc_ctrl_model (.clock_i(clock_i), .cke_o(cke), .cs_n_o(cs_n), .ras_n_o(ras_n),
    .cas_n_o(cas_n), .we_n_o(we_n), .ba_o(ba), .addr_o(addr), .burst_len_sel_o(bl),
    .lower_byte_mask_o(lmask), .upper_byte_mask_o(umask), .dq_o(wdata));

  sdpc_core i_sdpc_core (.clock_i(clock_i), .resetn_i(resetn_i), .cke_i(cke), .cs_n_i(cs_n),
    .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .ba_i(ba), .addr_i(addr), .burst_len_sel_i(bl),
    .lower_byte_mask_i(lmask), .upper_byte_mask_i(umask), .dq_i(wdata), .dq_o(rdata), .dq_oe_o(oe),
    .bank_open_o(bank_open), .pwr_state_o(pwr));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
    input logic [15:0] d = 16'h0000, input logic [1:0] m = 2'h0);
    i_sdpc_ctrl_model.drive(c, b, a, d, m);
  endtask

  task automatic nop(input int n);
    i_sdpc_ctrl_model.idle(n);
  endtask

  task automatic pins(input logic k, input logic [2:0] l);
    i_sdpc_ctrl_model.set_pins(k, l);
  endtask

  task automatic end_of_test();
    if (n_fail == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_write_read();
    pins(1'b1, sdpc_pkg::BL_2);
    cmd(sdpc_pkg::CMD_ACT, 2'h1, 13'h0000);
    cmd(sdpc_pkg::CMD_WRITE, 2'h1, 13'h0004, 16'h1111);
    cmd(4'hC, 2'h1, 13'h0000, 16'h2222);
    cmd(sdpc_pkg::CMD_WRITE, 2'h1, 13'h0004, 16'h3333, 2'h1);
    cmd(4'hC, 2'h1, 13'h0000, 16'h4444, 2'h2);
    nop(3);
    chk(bank_open, 4'h2);
    cmd(sdpc_pkg::CMD_READ, 2'h1, 13'h0004);
    nop(3);
    chk(rdata, 16'h3311);
    chk(oe, 2'h3);
    nop(1);
    chk(rdata, 16'h2244);
    nop(1);
    chk(oe, 2'h0);
  endtask

  task automatic t_read_mask();
    cmd(sdpc_pkg::CMD_READ, 2'h1, 13'h0004, 16'h0000, 2'h1);
    cmd(4'hF, 2'h1, 13'h0000, 16'h0000, 2'h1);
    cmd(4'hF, 2'h1, 13'h0000, 16'h0000, 2'h1);
    nop(1);
    chk(oe, 2'h2);
    chk(rdata[15:8], 8'h33);
    nop(1);
    chk(oe, 2'h2);
    chk(rdata[15:8], 8'h22);
  endtask

  task automatic t_burst_len();
    logic [2:0] code [4] = '{sdpc_pkg::BL_1, sdpc_pkg::BL_2, sdpc_pkg::BL_4, sdpc_pkg::BL_8};
    int beats [4] = '{sdpc_pkg::BEATS_1, sdpc_pkg::BEATS_2, sdpc_pkg::BEATS_4, sdpc_pkg::BEATS_8};
    int cnt;
    for (int i = 0; i < 4; i++)
    begin
      nop(2);
      pins(1'b1, code[i]);
      cmd(sdpc_pkg::CMD_READ, 2'h1, 13'h0000);
      cnt = 0;
      repeat (12)
      begin
        nop(1);
        cnt += int'(oe === 2'h3);
      end
      chk(16'(cnt), 16'(beats[i]));
    end
    // full page read cut by burst terminate on its third edge
    nop(2);
    pins(1'b1, sdpc_pkg::BL_PAGE);
    cmd(sdpc_pkg::CMD_READ, 2'h1, 13'h0000);
    cnt = 0;
    for (int k = 0; k < 12; k++)
    begin
      if (k == 2)
        cmd(sdpc_pkg::CMD_BST, 2'h1, 13'h0000);
      else
        nop(1);
      cnt += int'(oe === 2'h3);
    end
    chk(16'(cnt), 16'h0003);
  endtask

  task automatic t_select();
    int cnt;
    cmd(4'hD, 2'h1, 13'h0000);
    cmd(4'hB, 2'h3, 13'h0000);
    cnt = 0;
    repeat (5)
    begin
      nop(1);
      cnt += int'(oe !== 2'h0);
    end
    chk(16'(cnt), 16'h0000);
    chk(bank_open, 4'h2);
  endtask

  task automatic t_power();
    pins(1'b0, sdpc_pkg::BL_1);
    nop(1);
    chk(pwr, 3'h2);
    cmd(sdpc_pkg::CMD_ACT, 2'h2, 13'h0000);
    nop(1);
    chk(bank_open, 4'h2);
    chk(pwr, 3'h2);
    pins(1'b1, sdpc_pkg::BL_1);
    nop(1);
    chk(pwr, 3'h0);
    cmd(sdpc_pkg::CMD_ACT, 2'h0, 13'h0000);
    cmd(sdpc_pkg::CMD_PRE, 2'h1, 13'h0000);
    nop(1);
    chk(bank_open, 4'h1);
    cmd(sdpc_pkg::CMD_PRE, 2'h2, 13'h0400);
    nop(1);
    chk(bank_open, 4'h0);
    pins(1'b0, sdpc_pkg::BL_1);
    nop(1);
    chk(pwr, 3'h1);
    pins(1'b1, sdpc_pkg::BL_1);
    cmd(sdpc_pkg::CMD_REF, 2'h0, 13'h0000);
    pins(1'b0, sdpc_pkg::BL_1);
    nop(1);
    chk(pwr, 3'h3);
    pins(1'b1, sdpc_pkg::BL_8);
    cmd(sdpc_pkg::CMD_ACT, 2'h1, 13'h0000);
    cmd(sdpc_pkg::CMD_READ, 2'h1, 13'h0404);
    nop(3);
    pins(1'b0, sdpc_pkg::BL_8);
    nop(2);
    chk(pwr, 3'h4);
    chk(rdata, 16'h3311);
    chk(bank_open, 4'h2);
    pins(1'b1, sdpc_pkg::BL_8);
    nop(12);
    chk(bank_open, 4'h0);
  endtask

  // ----------------------------------------
  // main sequence and timeout
  // ----------------------------------------
  initial
  begin
    repeat (4) @(negedge clock_i);
    resetn_i = 1'b1;
    t_write_read();
    t_read_mask();
    t_burst_len();
    t_select();
    t_power();
    end_of_test();
  end

  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      end_of_test();
    end
  end
endmodule
